// File: src/rfo_bank.sv
// receive overhead capture and status register bank for one framer port
// assumes line strobes and host strobes are synchronous to CLK and one cycle long
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "rfo_consts.svh"

module rfo_bank
	import rfo_pkg::*;
#(
	parameter int PORT_NUM = 1,
	parameter int SRCH_CYCLES = `RFO_SRCH_CYCLES
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CE,
	input wire rfo_host_type HOST,
	input wire rfo_line_type LINE,
	output logic [7:0] RDATA
);

	localparam int TMR_W = $clog2(SRCH_CYCLES + 1);
	localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(SRCH_CYCLES - 1);
	localparam logic [2:0] PORT_SEL = 3'(PORT_NUM - 1);

	logic port_hit;
	logic [`RFO_OFS_W-1:0] ofs;
	logic rd_en;
	logic wr_en;
	logic [3:0] cfg;
	logic mode_e1;
	logic mode_d4;
	logic crc4_en;
	logic [4:0] chan_sel;
	logic [15:0] febc;
	logic [7:0] ds0_shift;
	logic [7:0] ds0_mon;
	logic [7:0] fdl_shift;
	logic [2:0] fdl_cnt;
	logic [5:0] fs_shift;
	logic [7:0] data_link;
	logic [5:0] boc;
	logic [TMR_W-1:0] srch_tmr;
	logic srch_expire;
	logic csc_clear;
	logic [5:0] crc4_search_counter;
	logic [2:0] hunt;
	logic [7:0] sync_status;
	logic [7:0] align;
	logic [7:0] nonalign;
	logic [7:0] si_even;
	logic [7:0] si_odd;
	logic [7:0] remote_alarm;
	logic [7:0] spare4;
	logic e1_frame;
	logic [7:0] next_rdata;

	// port decode: upper address bits pick the port copy
	assign port_hit = (HOST.addr[`RFO_ADDR_W-1:`RFO_OFS_W] == PORT_SEL);
	assign ofs = HOST.addr[`RFO_OFS_W-1:0];
	assign rd_en = CE && HOST.rd && port_hit;
	assign wr_en = CE && HOST.wr && port_hit;
	assign mode_e1 = cfg[`RFO_CFG_E1_BIT];
	assign mode_d4 = cfg[`RFO_CFG_D4_BIT];
	assign crc4_en = cfg[`RFO_CFG_CRC4_BIT];

	// configuration and channel select are the only writable bytes
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cfg <= 4'h0;
			chan_sel <= 5'h00;
		end else if (wr_en) begin
			if (ofs == `RFO_OFS_CFG) begin
				cfg <= HOST.wdata[3:0];
			end
			if (ofs == `RFO_OFS_CHAN_SEL) begin
				chan_sel <= HOST.wdata[4:0];
			end
		end
	end

	// far-end error B count snapshot
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			febc <= 16'h0000;
		end else if (CE) begin
			febc <= LINE.febc_count;
		end
	end

	// ds0 monitor: shift left so the first bit ends in bit 7
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ds0_shift <= `RFO_RESET_BYTE;
			ds0_mon <= `RFO_RESET_BYTE;
		end else if (CE && LINE.bit_valid && LINE.chan == chan_sel) begin
			ds0_shift <= {ds0_shift[6:0], LINE.bit_data};
			if (LINE.bit_pos == `RFO_DS0_LAST_POS) begin
				ds0_mon <= {ds0_shift[6:0], LINE.bit_data};
			end
		end
	end

	// T1 data link: shift right so the first bit ends in bit 0
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			fdl_shift <= `RFO_RESET_BYTE;
			fdl_cnt <= 3'h0;
			fs_shift <= 6'h00;
			data_link <= `RFO_RESET_BYTE;
		end else if (CE && !mode_e1) begin
			if (mode_d4) begin
				if (LINE.fdl_valid) begin
					fs_shift <= {LINE.fdl_bit, fs_shift[5:1]};
				end
				if (LINE.mf_boundary) begin
					data_link <= {2'h0, fs_shift};
				end
			end else if (LINE.fdl_valid) begin
				fdl_shift <= {LINE.fdl_bit, fdl_shift[7:1]};
				fdl_cnt <= fdl_cnt + 3'h1;
				if (fdl_cnt == `RFO_FDL_LAST_CNT) begin
					data_link <= {LINE.fdl_bit, fdl_shift[7:1]};
				end
			end
		end
	end

	// last valid bit-oriented code
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			boc <= 6'h00;
		end else if (CE && LINE.boc_valid) begin
			boc <= LINE.boc_code;
		end
	end

	// 8 ms multiframe search timer
	assign srch_expire = mode_e1 && crc4_en && LINE.crc4_hunt && (srch_tmr == TMR_LAST);
	assign csc_clear = !crc4_en || LINE.crc4_sync;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			srch_tmr <= '0;
		end else if (CE) begin
			if (!mode_e1 || !crc4_en || !LINE.crc4_hunt || srch_expire) begin
				srch_tmr <= '0;
			end else begin
				srch_tmr <= srch_tmr + TMR_W'(1);
			end
		end
	end

	// search counter: clear wins, then saturating count
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			crc4_search_counter <= 6'h00;
		end else if (CE) begin
			if (csc_clear) begin
				crc4_search_counter <= 6'h00;
			end else if (srch_expire && crc4_search_counter != `RFO_CSC_MAX) begin
				crc4_search_counter <= crc4_search_counter + 6'h01;
			end
		end
	end

	// hunt levels, not latched
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			hunt <= 3'h0;
		end else if (CE) begin
			hunt <= {LINE.crc4_hunt, LINE.cas_hunt, LINE.fas_hunt};
		end
	end

	assign sync_status = {crc4_search_counter[5:2], crc4_search_counter[0], hunt};

	// E1 time slot 0 capture
	assign e1_frame = CE && mode_e1 && LINE.frame_done;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			align <= `RFO_RESET_BYTE;
			nonalign <= `RFO_RESET_BYTE;
		end else if (e1_frame) begin
			if (LINE.frame_num[0]) begin
				nonalign <= LINE.ts0;
			end else begin
				align <= LINE.ts0;
			end
		end
	end

	// per-frame bits: frame 2i or 2i+1 lands in bit i
	for (genvar i = 0; i < 8; i++) begin : g_mf_bit
		always_ff @(posedge CLK or negedge RST_B) begin
			if (!RST_B) begin
				si_even[i] <= 1'b0;
				si_odd[i] <= 1'b0;
				remote_alarm[i] <= 1'b0;
				spare4[i] <= 1'b0;
			end else if (e1_frame && LINE.frame_num[3:1] == 3'(i)) begin
				if (LINE.frame_num[0]) begin
					si_odd[i] <= LINE.ts0[7];
					remote_alarm[i] <= LINE.ts0[5];
					spare4[i] <= LINE.ts0[4];
				end else begin
					si_even[i] <= LINE.ts0[7];
				end
			end
		end
	end

	// read mux; unmapped offsets, and in T1 mode the align, nonalign and Si even offsets, read zero
	always_comb begin
		next_rdata = `RFO_RESET_BYTE;
		case (ofs)
			`RFO_OFS_FEBC_HIGH: next_rdata = febc[15:8];
			`RFO_OFS_FEBC_LOW: next_rdata = febc[7:0];
			`RFO_OFS_CFG: next_rdata = {4'h0, cfg};
			`RFO_OFS_CHAN_SEL: next_rdata = {3'h0, chan_sel};
			`RFO_OFS_DS0_MON: next_rdata = ds0_mon;
			`RFO_OFS_DATA_LINK: next_rdata = mode_e1 ? sync_status : data_link;
			`RFO_OFS_BOC: next_rdata = {2'h0, boc};
			`RFO_OFS_ALIGN: next_rdata = mode_e1 ? align : `RFO_RESET_BYTE;
			`RFO_OFS_NONALIGN: next_rdata = mode_e1 ? nonalign : `RFO_RESET_BYTE;
			`RFO_OFS_SI_EVEN: next_rdata = mode_e1 ? si_even : `RFO_RESET_BYTE;
			`RFO_OFS_SI_ODD: next_rdata = si_odd;
			`RFO_OFS_REMOTE_ALARM: next_rdata = remote_alarm;
			`RFO_OFS_SPARE4: next_rdata = spare4;
			default: next_rdata = `RFO_RESET_BYTE;
		endcase
	end

	// read data stands until the next cycle with CE high
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			RDATA <= `RFO_RESET_BYTE;
		end else if (CE) begin
			RDATA <= rd_en ? next_rdata : `RFO_RESET_BYTE;
		end
	end

	// checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);

	AST_FEBC_LOW: assert property (
		(rd_en && ofs == `RFO_OFS_FEBC_LOW) |=> RDATA == $past(febc[7:0]))
		else $error("error B low byte read mismatch");

	AST_DS0_BYTE: assert property (
		(CE && LINE.bit_valid && LINE.chan == chan_sel && LINE.bit_pos == `RFO_DS0_LAST_POS)
		|=> ds0_mon == {$past(ds0_shift[6:0]), $past(LINE.bit_data)})
		else $error("ds0 monitor byte not taken");

	AST_FDL_BYTE: assert property (
		(CE && !mode_e1 && !mode_d4 && LINE.fdl_valid && fdl_cnt == `RFO_FDL_LAST_CNT)
		|=> data_link == {$past(LINE.fdl_bit), $past(fdl_shift[7:1])})
		else $error("data link byte not taken");

	AST_D4_HOLD: assert property (
		(CE && mode_d4 && !mode_e1 && !LINE.mf_boundary) |=> $stable(data_link))
		else $error("D4 data link changed off a multiframe boundary");

	AST_BOC_LAST: assert property (
		(CE && LINE.boc_valid) |=> boc == $past(LINE.boc_code))
		else $error("bit-oriented code not held");

	AST_BOC_READ: assert property (
		(rd_en && ofs == `RFO_OFS_BOC) |=> RDATA[7:6] == 2'h0)
		else $error("bit-oriented code upper bits not zero");

	AST_STATUS_READ: assert property (
		(rd_en && mode_e1 && ofs == `RFO_OFS_DATA_LINK)
		|=> RDATA == {$past(crc4_search_counter[5:2]), $past(crc4_search_counter[0]), $past(hunt)})
		else $error("E1 sync status read mismatch");

	AST_T1_SLC_ZERO: assert property (
		(rd_en && !mode_e1 && ofs >= `RFO_OFS_ALIGN && ofs <= `RFO_OFS_SI_EVEN)
		|=> RDATA == `RFO_RESET_BYTE)
		else $error("T1 link offset read not zero");

	AST_CSC_INC: assert property (
		(CE && srch_expire && !csc_clear && crc4_search_counter != `RFO_CSC_MAX) |=> crc4_search_counter == $past(crc4_search_counter) + 6'h01)
		else $error("search counter missed a timeout");

	AST_CSC_CLEAR: assert property (
		(CE && csc_clear) |=> crc4_search_counter == 6'h00)
		else $error("search counter not cleared");

	AST_CSC_SAT: assert property (
		(CE && crc4_search_counter == `RFO_CSC_MAX && !csc_clear) |=> crc4_search_counter == `RFO_CSC_MAX)
		else $error("search counter wrapped");

	AST_HUNT_FOLLOW: assert property (
		CE |=> hunt == {$past(LINE.crc4_hunt), $past(LINE.cas_hunt), $past(LINE.fas_hunt)})
		else $error("hunt status does not follow framer");

	AST_SI_EVEN: assert property (
		(e1_frame && !LINE.frame_num[0])
		|=> si_even[$past(LINE.frame_num[3:1])] == $past(LINE.ts0[7]))
		else $error("even-frame Si bit not captured");

	AST_ODD_FRAME: assert property (
		(e1_frame && LINE.frame_num[0])
		|=> remote_alarm[$past(LINE.frame_num[3:1])] == $past(LINE.ts0[5])
		&& spare4[$past(LINE.frame_num[3:1])] == $past(LINE.ts0[4]))
		else $error("odd-frame alarm or spare bit not captured");

	AST_RO_WRITE: assert property (
		(wr_en && !LINE.frame_done) |=> $stable(si_even) && $stable(spare4))
		else $error("host write disturbed captured bits");

	COV_CSC_SAT: cover property (CE && srch_expire && crc4_search_counter == `RFO_CSC_MAX);
	COV_DS0: cover property (CE && LINE.bit_valid && LINE.chan == chan_sel && LINE.bit_pos == 3'h7);
	COV_E1_STATUS: cover property (rd_en && mode_e1 && ofs == `RFO_OFS_DATA_LINK);
	COV_ODD_FRAME: cover property (e1_frame && LINE.frame_num == 4'hF);

endmodule : rfo_bank

`default_nettype wire

// File: src/rfo_consts.svh
// offsets, field positions, reset values and timing counts of the rx overhead bank
// assumes inclusion by the package and the bank module only
`ifndef RFO_CONSTS_SVH
`define RFO_CONSTS_SVH

`define RFO_ADDR_W 12
`define RFO_OFS_W 9
`define RFO_PORT_STRIDE 12'h200
`define RFO_PORTS 8

`define RFO_OFS_FEBC_HIGH 9'h05A
`define RFO_OFS_FEBC_LOW 9'h05B
`define RFO_OFS_CFG 9'h05E
`define RFO_OFS_CHAN_SEL 9'h05F
`define RFO_OFS_DS0_MON 9'h060
`define RFO_OFS_DATA_LINK 9'h062
`define RFO_OFS_BOC 9'h063
`define RFO_OFS_ALIGN 9'h064
`define RFO_OFS_NONALIGN 9'h065
`define RFO_OFS_SI_EVEN 9'h066
`define RFO_OFS_SI_ODD 9'h067
`define RFO_OFS_REMOTE_ALARM 9'h068
`define RFO_OFS_SPARE4 9'h069

`define RFO_CFG_E1_BIT 0
`define RFO_CFG_D4_BIT 1
`define RFO_CFG_CRC4_BIT 3

`define RFO_RESET_BYTE 8'h00
`define RFO_CSC_MAX 6'h3F
`define RFO_DS0_LAST_POS 3'h7
`define RFO_FDL_LAST_CNT 3'h7

`define RFO_CLK_MHZ 40
`define RFO_SRCH_TIME_US 8000
`define RFO_SRCH_CYCLES (`RFO_SRCH_TIME_US * `RFO_CLK_MHZ)

`endif

// File: src/rfo_pkg.sv
// types shared by the rx overhead bank and its surroundings
// assumes the constants header sits beside it
`default_nettype none
`include "rfo_consts.svh"

package rfo_pkg;

	// per-cycle capture strobes from the line-side receive framer
	typedef struct packed {
		logic [15:0] febc_count;
		logic bit_valid;
		logic bit_data;
		logic [4:0] chan;
		logic [2:0] bit_pos;
		logic fdl_valid;
		logic fdl_bit;
		logic mf_boundary;
		logic boc_valid;
		logic [5:0] boc_code;
		logic crc4_sync;
		logic crc4_hunt;
		logic cas_hunt;
		logic fas_hunt;
		logic frame_done;
		logic [3:0] frame_num;
		logic [7:0] ts0;
	} rfo_line_type;

	// host register port
	typedef struct packed {
		logic [`RFO_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rfo_host_type;

endpackage : rfo_pkg

`default_nettype wire

// File: tb/rfo_line_model.sv
// line-side receive framer model feeding capture strobes to the bank
// assumes one clock shared with the bank; strobes are one cycle long
`timescale 1ns/1ps
`default_nettype none

module rfo_line_model
	import rfo_pkg::*;
(
	input wire logic CLK,
	output var rfo_line_type LINE
);
	rfo_line_type b;
	rfo_line_type q;
	initial begin
		b = '0;
		LINE = '0;
	end
	// one strobe cycle, then idle with data lines scrambled
	task automatic strobe();
		@(posedge CLK);
		LINE <= b;
		q = ~b;
		q.febc_count = b.febc_count;
		{q.crc4_hunt, q.cas_hunt, q.fas_hunt} = {b.crc4_hunt, b.cas_hunt, b.fas_hunt};
		{q.bit_valid, q.fdl_valid, q.mf_boundary, q.boc_valid, q.crc4_sync, q.frame_done} = '0;
		@(posedge CLK);
		LINE <= q;
		{b.bit_valid, b.fdl_valid, b.mf_boundary, b.boc_valid, b.crc4_sync, b.frame_done} = '0;
	endtask : strobe
	task automatic ds0(input logic [4:0] c, input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			b.bit_valid = 1'b1;
			b.chan = c;
			b.bit_pos = i[2:0];
			b.bit_data = d[7-i];
			strobe();
		end
	endtask : ds0
	// link bits leave least significant first
	task automatic fdl(input logic [7:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			b.fdl_valid = 1'b1;
			b.fdl_bit = v[i];
			strobe();
		end
	endtask : fdl
	task automatic frame(input logic [3:0] n, input logic [7:0] t);
		b.frame_done = 1'b1;
		b.frame_num = n;
		b.ts0 = t;
		strobe();
	endtask : frame
endmodule : rfo_line_model

`default_nettype wire

// File: tb/test_rfo_bank.sv
// self-checking bench for the rx overhead bank, port 3, short search timer
// assumes the line model drives every capture strobe
`timescale 1ns/1ps
`default_nettype none

module test_rfo_bank
	import rfo_pkg::*;
;
	logic CLK = 1'b0;
	logic RST_B = 1'b0;
	logic ce = 1'b1;
	rfo_host_type host = '0;
	rfo_line_type line;
	logic [7:0] rdata;
	int bad_count = 0;
	int n_checks = 0;
	always #12.5 CLK = ~CLK;
	rfo_line_model m (.CLK(CLK), .LINE(line));
	rfo_bank #(.PORT_NUM(3), .SRCH_CYCLES(8)) dut (.CLK(CLK), .RST_B(RST_B), .CE(ce),
		.HOST(host), .LINE(line), .RDATA(rdata));
	task automatic cmp(input logic [11:0] a, input logic [7:0] e);
		n_checks++;
		if (rdata !== e) begin
			bad_count++;
			$display("MISMATCH reg %h expected %h seen %h", a, e, rdata);
		end
	endtask : cmp
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge CLK) host <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge CLK) host.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge CLK) host <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge CLK) host.rd <= 1'b0;
		#1 cmp(a, e);
	endtask : rd
	task automatic wrap_up();
		if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up
	task automatic t_count();
		for (int o = 'h5A; o <= 'h69; o++) rd(12'h400 + o[11:0], 8'h00);
		m.b.febc_count = 16'hA55A;
		m.strobe();
		rd(12'h45A, 8'hA5);
		rd(12'h45B, 8'h5A);
		rd(12'h05B, 8'h00);
		wr(12'h45B, 8'hFF);
		rd(12'h45B, 8'h5A);
	endtask : t_count
	task automatic t_link();
		wr(12'h45F, 8'h03);
		m.ds0(5'd3, 8'hC3);
		m.ds0(5'd4, 8'h55);
		rd(12'h460, 8'hC3);
		m.fdl(8'h96, 8);
		rd(12'h462, 8'h96);
		m.b.boc_valid = 1'b1;
		m.b.boc_code = 6'h2A;
		m.strobe();
		wr(12'h463, 8'hFF);
		rd(12'h463, 8'h2A);
		@(posedge CLK) ce <= 1'b0;
		m.b.boc_valid = 1'b1;
		m.b.boc_code = 6'h15;
		m.strobe();
		@(posedge CLK) ce <= 1'b1;
		rd(12'h463, 8'h2A);
		wr(12'h45E, 8'h02);
		m.fdl(8'h2D, 6);
		rd(12'h462, 8'h96);
		m.b.mf_boundary = 1'b1;
		m.strobe();
		rd(12'h462, 8'h2D);
	endtask : t_link
	task automatic t_frames();
		logic [7:0] se;
		logic [7:0] so;
		logic [7:0] ra;
		logic [7:0] s4;
		se = 8'h96;
		so = 8'h5C;
		ra = 8'hA3;
		s4 = 8'h3A;
		wr(12'h45E, 8'h01);
		for (int f = 0; f < 16; f++) begin
			if (f % 2 == 0) m.frame(f[3:0], {se[f/2], 7'h1B});
			else m.frame(f[3:0], {so[f/2], 1'b1, ra[f/2], s4[f/2], 4'hA});
		end
		rd(12'h464, 8'h9B);
		rd(12'h465, 8'h6A);
		rd(12'h466, se);
		rd(12'h467, so);
		rd(12'h468, ra);
		rd(12'h469, s4);
	endtask : t_frames
	task automatic t_search();
		wr(12'h45E, 8'h09);
		{m.b.crc4_hunt, m.b.cas_hunt, m.b.fas_hunt} = 3'b110;
		m.strobe();
		repeat (40) @(posedge CLK);
		rd(12'h462, 8'h1E);
		repeat (600) @(posedge CLK);
		rd(12'h462, 8'hFE);
		wr(12'h45E, 8'h01);
		rd(12'h462, 8'h06);
		wr(12'h45E, 8'h09);
		repeat (28) @(posedge CLK);
		{m.b.crc4_hunt, m.b.cas_hunt, m.b.fas_hunt} = 3'b001;
		m.b.crc4_sync = 1'b1;
		m.strobe();
		rd(12'h462, 8'h01);
	endtask : t_search
	initial begin
		repeat (5000) @(posedge CLK);
		bad_count++;
		wrap_up();
	end
	initial begin
		repeat (3) @(posedge CLK);
		RST_B <= 1'b1;
		t_count();
		t_link();
		t_frames();
		t_search();
		wrap_up();
	end
endmodule : test_rfo_bank

`default_nettype wire
